// ### npe_engine.sv
// nand page code engine: wishbone slave, parity fold, read-back check
// Notes on behaviour
// - correct one bad bit, detect two, flag more as uncorrectable
// - page words are 8 or 16 bits wide; page size counts main plus spare
// - mode field picks page length 528, 2112 or 4224 words
// - mode field picks one code per page, per 256 or per 512 bytes
// - flash command 00h or 80h starts parity computation
// - results become available when the counter hits the last main word
// - parity results stay frozen until the next command plus address
// - only as many result registers as segments carry meaning
// - registers answer as a bus slave
// - read-back sets recoverable, code-error or multiple flags with location
// - status and parity clear on each 00h or 80h command and on soft reset
// - writing one to the parity reset bit clears results; zero does nothing
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/10ps
module npe_engine (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// flash bus monitor
	input wire logic nand_cmd_i,
	input wire logic nand_addr_i,
	input wire logic nand_data_valid_i,
	input wire logic [15:0] nand_data_i,
	// interrupt
	output logic irq_o
);
	import npe_pkg::*;

	npe_state_e state_reg, state_next;
	logic ack_reg;
	logic [31:0] dat_reg;
	logic pr_rd_reg;
	logic pr_ok_reg;
	logic [7:0] code_mode_reg;
	logic [ST_W-1:0] code_status_reg1;
	logic [ST_W-1:0] mask_reg;
	logic [NUM_PR-1:0] valid_reg;
	logic [NUM_PR-1:0] seg_err_reg;
	logic op_read_reg;
	logic [12:0] word_cnt_reg, seg_cnt_reg;
	logic [4:0] seg_idx_reg, chk_idx_reg;
	logic [11:0] row_even_reg, row_odd_reg;
	logic [15:0] col_reg;
	logic [1:0] piece_reg;
	logic [31:0] stored_reg;
	logic chk_pend_reg;
	logic [31:0] mem_rd_a, mem_rd_b;

	////////////////////////////////////////////////////////////////////////
	// bus decode
	wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
	wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
	wire bus_rd = bus_req & ~wb_we_i;
	wire [5:0] wadr = wb_adr_i[7:2];
	wire hit_pr01 = (wb_adr_i == OFS_PR0) | (wb_adr_i == OFS_PR1);
	wire hit_prn = (wb_adr_i >= OFS_PR2) & (wb_adr_i <= OFS_PR15);
	wire hit_pr = hit_pr01 | hit_prn;
	wire [5:0] pr_idx6 = (wb_adr_i == OFS_PR0) ? 6'h00 :
		(wb_adr_i == OFS_PR1) ? 6'h01 : wadr - 6'h04;
	wire [PR_AW-1:0] pr_idx = pr_idx6[PR_AW-1:0];
	wire wr_ctrl = bus_wr & (wb_adr_i == OFS_CTRL);
	wire wr_mode = bus_wr & (wb_adr_i == OFS_MODE);
	wire wr_mask = bus_wr & (wb_adr_i == OFS_MASK);
	wire rd_sr1 = bus_rd & (wb_adr_i == OFS_SR1);
	wire soft_rst = wr_ctrl & wb_dat_i[CTRL_SRST];
	wire par_rst = wr_ctrl & wb_dat_i[CTRL_PRST];

	////////////////////////////////////////////////////////////////////////
	// page geometry from the mode register
	wire [1:0] psel = code_mode_reg[MODE_PSEL_LO +: 2];
	wire [1:0] gran = code_mode_reg[MODE_GRAN_LO +: 2];
	wire w16 = code_mode_reg[MODE_W16];
	wire [12:0] main_words = (psel == PSEL_2112) ? MAIN_2112 :
		(psel == PSEL_4224) ? MAIN_4224 : MAIN_528;
	// segment length per granularity, halved for wide words except with one code per page
	wire [12:0] seg_bytes = (gran == GRAN_512) ? SEG_512 : SEG_256;
	wire [12:0] seg_words = (gran == GRAN_PAGE) ? main_words :
		(w16 ? (seg_bytes >> 1) : seg_bytes);
	wire [12:0] main_last = main_words - 13'h0001;
	wire [12:0] seg_last = seg_words - 13'h0001;
	wire [11:0] row_used = seg_last[11:0];
	wire [3:0] col_used = w16 ? 4'hf : 4'h7;
	wire [5:0] nseg6 = (gran == GRAN_PAGE) ? 6'h01 :
		6'((main_words >> 8) >> ((gran == GRAN_512) ? 1 : 0) << w16);
	// only the first sixteen segments are checked; 32 would wrap a 5-bit compare
	wire [4:0] nseg_chk = (nseg6 > 6'h10) ? 5'd16 : nseg6[4:0];

	////////////////////////////////////////////////////////////////////////
	// flash monitor events
	wire start_cmd = nand_cmd_i & ((nand_data_i[7:0] == CMD_READ) |
		(nand_data_i[7:0] == CMD_PROG));
	wire in_data = (state_reg == ST_ADDR) | (state_reg == ST_MAIN);
	// command and address cycles never count as page data
	wire take_word = nand_data_valid_i & ~nand_cmd_i & ~nand_addr_i & in_data;
	wire main_end = take_word & (word_cnt_reg == main_last);
	wire seg_end = take_word & (seg_cnt_reg == seg_last);
	wire [15:0] word_v = w16 ? nand_data_i : {8'h00, nand_data_i[7:0]};
	wire word_par = ^word_v;
	// a code byte may follow the check cycle directly, so none is dropped then
	wire take_code = nand_data_valid_i & ~nand_addr_i & (state_reg == ST_SPARE);
	wire code_last = take_code & (piece_reg == (w16 ? 2'h1 : 2'h3));
	wire clr_all = start_cmd | soft_rst;

	////////////////////////////////////////////////////////////////////////
	// running parity with this word folded in
	logic [11:0] row_even_n, row_odd_n;
	logic [15:0] col_n;
	logic [3:0] col_even, col_odd;
	logic [15:0] col_m [4];
	assign col_m[0] = COL_M0;
	assign col_m[1] = COL_M1;
	assign col_m[2] = COL_M2;
	assign col_m[3] = COL_M3;
	assign col_n = col_reg ^ word_v;
	// row parity split by each word-index bit, column by bit index
	genvar gi;
	generate
		for (gi = 0; gi < 12; gi++) begin : g_row
			assign row_odd_n[gi] = row_odd_reg[gi] ^ (word_par & seg_cnt_reg[gi]);
			assign row_even_n[gi] = row_even_reg[gi] ^
				(word_par & ~seg_cnt_reg[gi] & row_used[gi]);
		end
		for (gi = 0; gi < 4; gi++) begin : g_col
			assign col_odd[gi] = ^(col_n & col_m[gi]) & col_used[gi];
			assign col_even[gi] = ^(col_n & ~col_m[gi]) & col_used[gi];
		end
	endgenerate
	wire [31:0] seg_code = {col_odd, col_even, row_odd_n, row_even_n};

	////////////////////////////////////////////////////////////////////////
	// read-back check of a stored code against the computed one
	wire [31:0] syn = stored_reg ^ mem_rd_b;
	wire [11:0] syn_row_x = syn[23:12] ^ syn[11:0];
	wire [3:0] syn_col_x = syn[31:28] ^ syn[27:24];
	wire syn_zero = (syn == 32'h0000_0000);
	wire syn_one = ~syn_zero & ((syn & (syn - 32'h0000_0001)) == 32'h0000_0000);
	wire syn_rec = (syn_row_x == row_used) & (syn_col_x == col_used);
	wire chk_go = chk_pend_reg & op_read_reg;
	// one bad data bit is correctable, a lone code bit is code error
	wire ev_rec = chk_go & syn_rec;
	wire ev_code = chk_go & ~syn_rec & syn_one;
	wire ev_mult = chk_go & ~syn_zero & ~syn_rec & ~syn_one;
	wire [ST_W-1:0] events = {main_end, ev_mult, ev_code, ev_rec};

	// result memory write: segment code, or location on a fixable error
	wire seg_ok = (seg_idx_reg < 5'd16);
	wire mem_we = (seg_end & seg_ok) | ev_rec;
	wire [PR_AW-1:0] mem_wa = ev_rec ? chk_idx_reg[PR_AW-1:0] : seg_idx_reg[PR_AW-1:0];
	wire [31:0] mem_wd = ev_rec ? {16'h0000, syn[23:12], syn[31:28]} : seg_code;

	npe_result_mem u_mem (
		.clk_i(clk_i),
		.we_i(mem_we),
		.waddr_i(mem_wa),
		.wdata_i(mem_wd),
		.raddr_a_i(pr_idx),
		.rdata_a_o(mem_rd_a),
		.raddr_b_i(chk_idx_reg[PR_AW-1:0]),
		.rdata_b_o(mem_rd_b)
	);

	////////////////////////////////////////////////////////////////////////
	// engine state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: state_next = ST_IDLE;
			ST_ADDR: state_next = main_end ? ST_DONE : (take_word ? ST_MAIN : ST_ADDR);
			ST_MAIN: state_next = main_end ? (op_read_reg ? ST_SPARE : ST_DONE) : ST_MAIN;
			ST_SPARE: state_next = (chk_go & (chk_idx_reg + 5'd1 >= nseg_chk)) ?
				ST_DONE : ST_SPARE;
			ST_DONE: state_next = ST_DONE;
			default: state_next = ST_IDLE;
		endcase
		// read or program command restarts the engine
		if (start_cmd) begin
			state_next = ST_ADDR;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			op_read_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (start_cmd) begin
				op_read_reg <= (nand_data_i[7:0] == CMD_READ);
			end
		end
	end

	// word and segment counters run from the first data word
	// no page-offset tracking: counting assumes a page-aligned start
	always_ff @(posedge clk_i) begin
		if (rst_i | start_cmd) begin
			word_cnt_reg <= 13'h0000;
			seg_cnt_reg <= 13'h0000;
			seg_idx_reg <= 5'd0;
		end else if (take_word) begin
			word_cnt_reg <= word_cnt_reg + 13'h0001;
			seg_cnt_reg <= seg_end ? 13'h0000 : seg_cnt_reg + 13'h0001;
			seg_idx_reg <= seg_end ? seg_idx_reg + 5'd1 : seg_idx_reg;
		end
	end

	// parity accumulators restart at each segment edge
	always_ff @(posedge clk_i) begin
		if (rst_i | start_cmd | seg_end) begin
			row_even_reg <= 12'h000;
			row_odd_reg <= 12'h000;
			col_reg <= 16'h0000;
		end else if (take_word) begin
			row_even_reg <= row_even_n;
			row_odd_reg <= row_odd_n;
			col_reg <= col_n;
		end
	end

	// stored codes follow the main area, low byte or word first
	always_ff @(posedge clk_i) begin
		if (rst_i | start_cmd) begin
			piece_reg <= 2'h0;
			stored_reg <= 32'h0000_0000;
			chk_pend_reg <= 1'b0;
			chk_idx_reg <= 5'd0;
		end else begin
			if (take_code) begin
				piece_reg <= code_last ? 2'h0 : piece_reg + 2'h1;
				stored_reg <= w16 ? {nand_data_i, stored_reg[31:16]} :
					{nand_data_i[7:0], stored_reg[31:8]};
			end
			chk_pend_reg <= code_last & (chk_idx_reg < 5'd16);
			if (chk_go) begin
				chk_idx_reg <= chk_idx_reg + 5'd1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// result validity and per-segment error summary
	// a read or program command or soft reset empties results
	// parity reset bit clears results, zero in it does nothing
	// no other path clears valid results, and only a recoverable-error location rewrites one, until a restart
	// a segment finishing in the parity-reset cycle still lands: set wins
	always_ff @(posedge clk_i) begin
		if (rst_i | clr_all) begin
			valid_reg <= '0;
			seg_err_reg <= '0;
		end else begin
			if (par_rst) begin
				valid_reg <= '0;
				seg_err_reg <= '0;
			end
			if (seg_end & seg_ok) begin
				valid_reg[seg_idx_reg[PR_AW-1:0]] <= 1'b1;
			end
			if (ev_rec | ev_code | ev_mult) begin
				seg_err_reg[chk_idx_reg[PR_AW-1:0]] <= 1'b1;
			end
		end
	end

	// sticky flags, cleared by a status read, set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i | clr_all) begin
			code_status_reg1 <= '0;
		end else begin
			code_status_reg1 <= (rd_sr1 ? '0 : code_status_reg1) | events;
		end
	end

	// software sets width, length and granularity
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			code_mode_reg <= MODE_RESET;
			mask_reg <= '0;
		end else begin
			if (wr_mode) begin
				code_mode_reg <= wb_dat_i[7:0] & MODE_MASK;
			end
			if (wr_mask) begin
				mask_reg <= wb_dat_i[ST_W-1:0];
			end
		end
	end

	assign irq_o = |(code_status_reg1 & mask_reg);

	////////////////////////////////////////////////////////////////////////
	// one-wait-state answer, unmapped reads give zero
	wire [31:0] rd_mux = (wb_adr_i == OFS_MODE) ? {24'h0, code_mode_reg} :
		(wb_adr_i == OFS_SR1) ? {28'h0, code_status_reg1} :
		(wb_adr_i == OFS_SR2) ? {16'h0, seg_err_reg} :
		(wb_adr_i == OFS_MASK) ? {28'h0, mask_reg} : 32'h0000_0000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
			pr_rd_reg <= 1'b0;
			pr_ok_reg <= 1'b0;
		end else begin
			ack_reg <= bus_req;
			dat_reg <= bus_rd ? rd_mux : 32'h0000_0000;
			pr_rd_reg <= bus_rd & hit_pr;
			pr_ok_reg <= valid_reg[pr_idx];
		end
	end

	// a result word reads zero unless its segment was computed
	assign wb_dat_o = pr_rd_reg ? (pr_ok_reg ? mem_rd_a : 32'h0000_0000) : dat_reg;
	assign wb_ack_o = ack_reg;

	////////////////////////////////////////////////////////////////////////
	// checks
	chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack held more than one cycle");
	chk_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack not given");
	chk_start_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		start_cmd |=> (code_status_reg1 == '0) && (valid_reg == '0))
		else $error("command did not clear status and results");
	chk_prst_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		(par_rst && !(seg_end && seg_ok)) |=> (valid_reg == '0)) else $error("parity reset ignored");
	chk_ready_end: assert property (@(posedge clk_i) disable iff (rst_i)
		(main_end && !start_cmd && !soft_rst) |=> code_status_reg1[ST_READY])
		else $error("ready flag missing at main end");
	chk_frozen_done: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_reg == ST_DONE && !clr_all && !par_rst) |=> $stable(valid_reg))
		else $error("results changed while frozen");
	chk_cmd_start: assert property (@(posedge clk_i) disable iff (rst_i)
		start_cmd |=> (state_reg == ST_ADDR) && (word_cnt_reg == 13'h0000))
		else $error("command did not arm counting");
	chk_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
		(take_word && !start_cmd) |=> word_cnt_reg == $past(word_cnt_reg) + 13'h0001)
		else $error("word counter skipped");
	chk_ignore_ctl: assert property (@(posedge clk_i) disable iff (rst_i)
		(!nand_data_valid_i && !start_cmd && !seg_end) |=> $stable(col_reg))
		else $error("non-data cycle folded");
	chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		(ev_mult && mask_reg[ST_MULT] && !clr_all) |=> irq_o)
		else $error("masked-in error raised no interrupt");
endmodule

// ### npe_pkg.sv
// constants shared by the nand page code engine
package npe_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_SR1 = 8'h08;
	localparam logic [7:0] OFS_PR0 = 8'h0c;
	localparam logic [7:0] OFS_PR1 = 8'h10;
	localparam logic [7:0] OFS_SR2 = 8'h14;
	localparam logic [7:0] OFS_PR2 = 8'h18;
	localparam logic [7:0] OFS_PR15 = 8'h4c;
	localparam logic [7:0] OFS_MASK = 8'h80;
	// control register bits
	localparam int CTRL_PRST = 0;
	localparam int CTRL_SRST = 1;
	// mode register fields
	localparam int MODE_PSEL_LO = 0;
	localparam int MODE_W16 = 2;
	localparam int MODE_GRAN_LO = 4;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] MODE_MASK = 8'h37;
	// status bits
	localparam int ST_REC = 0;
	localparam int ST_CODE = 1;
	localparam int ST_MULT = 2;
	localparam int ST_READY = 3;
	localparam int ST_W = 4;
	// page length selections and main-area word counts
	localparam logic [1:0] PSEL_528 = 2'h0;
	localparam logic [1:0] PSEL_2112 = 2'h1;
	localparam logic [1:0] PSEL_4224 = 2'h2;
	localparam logic [12:0] MAIN_528 = 13'h0200;
	localparam logic [12:0] MAIN_2112 = 13'h0800;
	localparam logic [12:0] MAIN_4224 = 13'h1000;
	// correction granularity codes and segment sizes in bytes
	localparam logic [1:0] GRAN_PAGE = 2'h0;
	localparam logic [1:0] GRAN_256 = 2'h1;
	localparam logic [1:0] GRAN_512 = 2'h2;
	localparam logic [12:0] SEG_256 = 13'h0100;
	localparam logic [12:0] SEG_512 = 13'h0200;
	// flash commands that open a protected transfer
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CMD_PROG = 8'h80;
	// result storage
	localparam int NUM_PR = 16;
	localparam int PR_AW = 4;
	// column parity masks, one per bit of the bit index
	localparam logic [15:0] COL_M0 = 16'haaaa;
	localparam logic [15:0] COL_M1 = 16'hcccc;
	localparam logic [15:0] COL_M2 = 16'hf0f0;
	localparam logic [15:0] COL_M3 = 16'hff00;
	// engine states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_MAIN = 3'b010,
		ST_SPARE = 3'b011,
		ST_DONE = 3'b100
	} npe_state_e;
endpackage

// ### npe_result_mem.sv
// result store: one write port, two registered read ports
`timescale 1ns/10ps
module npe_result_mem (
	// clock
	input wire logic clk_i,
	// write port
	input wire logic we_i,
	input wire logic [npe_pkg::PR_AW-1:0] waddr_i,
	input wire logic [31:0] wdata_i,
	// bus read port
	input wire logic [npe_pkg::PR_AW-1:0] raddr_a_i,
	output logic [31:0] rdata_a_o,
	// engine read port
	input wire logic [npe_pkg::PR_AW-1:0] raddr_b_i,
	output logic [31:0] rdata_b_o
);
	import npe_pkg::*;

	logic [31:0] mem [NUM_PR];

	// contents need no reset: a valid vector outside masks stale words
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_a_o <= mem[raddr_a_i];
		rdata_b_o <= mem[raddr_b_i];
	end
endmodule

// ### npe_flash_model.sv
// behavioural flash bus partner: command, address cycles and page words
`timescale 1ns/10ps
module npe_flash_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// transfer request from the bench
	input wire logic go_i,
	input wire logic [7:0] cmd_i,
	input wire logic [12:0] nwords_i,
	input wire logic slow_i,
	output logic busy_o,
	// flash bus as seen by the engine
	output logic nand_cmd_o,
	output logic nand_addr_o,
	output logic nand_valid_o,
	output logic [15:0] nand_data_o
);
	logic [15:0] mem [0:4159];
	////////////////////////////////////////////////////////////////////////
	// one transfer; an idle bus shows inverted data so a stale word never matches
	task automatic run_page();
		busy_o <= 1'b1;
		nand_cmd_o <= 1'b1;
		nand_data_o <= {8'h00, cmd_i};
		@(posedge clk_i);
		nand_cmd_o <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			nand_addr_o <= 1'b1;
			nand_data_o <= 16'(k);
			@(posedge clk_i);
		end
		nand_addr_o <= 1'b0;
		// words from page start, main then codes, with random idle gaps when slow_i is set
		for (int j = 0; j < 32'(nwords_i); j++) begin
			if (slow_i && $urandom_range(1) == 1) begin
				nand_valid_o <= 1'b0;
				nand_data_o <= ~nand_data_o;
				@(posedge clk_i);
			end
			nand_valid_o <= 1'b1;
			nand_data_o <= mem[j];
			@(posedge clk_i);
		end
		nand_valid_o <= 1'b0;
		nand_data_o <= ~nand_data_o;
		busy_o <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	// idle until asked, requests are sampled on the rising edge
	initial begin
		busy_o = 1'b0;
		nand_cmd_o = 1'b0;
		nand_addr_o = 1'b0;
		nand_valid_o = 1'b0;
		nand_data_o = 16'h5a5a;
		forever begin
			@(posedge clk_i);
			if (!rst_i && go_i)
				run_page();
		end
	end
endmodule

// ### npe_engine_tb.sv
// self-checking bench for the nand page code engine
`timescale 1ns/10ps
module npe_engine_tb;
	import npe_pkg::*;
	typedef struct {logic [31:0] exp; logic [31:0] msk;} npe_note_s;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0, wb_dat_o;
	logic wb_ack_o, irq_o, nand_cmd, nand_addr, nand_valid, busy;
	logic [15:0] nand_data;
	logic go = 1'b0, slow = 1'b0;
	logic [7:0] cmd = 8'h00;
	logic [12:0] nwords = 13'h0;
	logic [7:0] zofs [7] = '{OFS_MODE, OFS_SR1, OFS_SR2, OFS_PR0, OFS_PR15, OFS_MASK, 8'hfc};
	// table of {page length, 16-bit words, granularity}
	logic [4:0] cfg [5] = '{5'h00, 5'h01, 5'h0e, 5'h12, 5'h15};
	npe_note_s notes [$];
	int miscompares = 0;
	int total_checks = 0;
	always #25 clk_i = ~clk_i;
	npe_engine npe_engine_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .nand_cmd_i(nand_cmd), .nand_addr_i(nand_addr),
		.nand_data_valid_i(nand_valid), .nand_data_i(nand_data), .irq_o(irq_o));
	npe_flash_model npe_flash_model_i (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .cmd_i(cmd),
		.nwords_i(nwords), .slow_i(slow), .busy_o(busy), .nand_cmd_o(nand_cmd),
		.nand_addr_o(nand_addr), .nand_valid_o(nand_valid), .nand_data_o(nand_data));
	////////////////////////////////////////////////////////////////////////
	task automatic fail(input string m);
		miscompares++;
		$display("MISMATCH %0t %s", $time, m);
	endtask
	task automatic finish_test();
		if (miscompares == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check_read(input npe_note_s n);
		if (n.msk != 32'h0) begin
			total_checks++;
			if ((wb_dat_o & n.msk) !== (n.exp & n.msk))
				fail($sformatf("read %h exp %h", wb_dat_o, n.exp));
		end
	endtask
	task automatic check_irq(input logic e);
		total_checks++;
		if (irq_o !== e)
			fail("interrupt level");
	endtask
	// oldest note against the read data, taken at the edge that sees ack
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1) begin
			if (notes.size() == 0) begin
				fail("ack without request");
			end else begin
				check_read(notes.pop_front());
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// classic single cycle; caller enters just after a rising edge
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		input logic [3:0] sel, input logic [31:0] msk);
		int n;
		notes.push_back('{exp: dat, msk: we ? 32'h0 : msk});
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= sel;
		wb_dat <= we ? dat : 32'h0;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20)
			fail("no acknowledge");
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb_xfer(1'b1, a, d, 4'hf, 32'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		wb_xfer(1'b0, a, e, 4'hf, m);
	endtask
	task automatic run_flash(input logic [7:0] c, input logic [12:0] n);
		int t;
		cmd <= c;
		nwords <= n;
		slow <= 1'($urandom_range(1));
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (busy === 1'b1 && t < 20000);
		if (t >= 20000)
			fail("flash transfer hung");
		repeat (4) @(posedge clk_i);
	endtask
	function automatic logic [7:0] pr_ofs(input int k);
		return (k < 2) ? 8'(OFS_PR0 + 4 * k) : 8'(OFS_PR2 + 4 * (k - 2));
	endfunction
	// reference code: row parity by word index bits, column parity by bit index bits
	function automatic logic [31:0] calc_code(input int base, input int nw, input bit w16);
		logic [11:0] er = '0, orw = '0;
		logic [3:0] ec = '0, oc = '0;
		logic [15:0] w;
		for (int j = 0; j < nw; j++) begin
			w = npe_flash_model_i.mem[base + j] & (w16 ? 16'hffff : 16'h00ff);
			for (int i = 0; i < $clog2(nw); i++)
				if (j[i]) orw[i] ^= ^w; else er[i] ^= ^w;
			for (int b = 0; b < (w16 ? 16 : 8); b++)
				for (int k = 0; k < (w16 ? 4 : 3); k++)
					if (b[k]) oc[k] ^= w[b]; else ec[k] ^= w[b];
		end
		return {oc, ec, orw, er};
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge clk_i);
		fail("watchdog");
		finish_test();
	end
	initial begin
		logic [31:0] code;
		int main_w, seg_w, nseg, j, b;
		logic w16;
		void'($urandom(32'h1ebcdf5a));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		foreach (zofs[k]) rd(zofs[k], 32'h0, '1);
		check_irq(1'b0);
		wr(OFS_MODE, '1);
		rd(OFS_MODE, {24'h0, MODE_MASK}, '1);
		wb_xfer(1'b1, OFS_MODE, 32'h0, 4'he, 32'h0);
		rd(OFS_MODE, {24'h0, MODE_MASK}, '1);
		wr(OFS_MASK, 32'h8);
		// program pages in every length, width and granularity
		for (int c = 0; c < 5; c++) begin
			w16 = cfg[c][2];
			main_w = (cfg[c][4:3] == PSEL_528) ? 512 : (cfg[c][4:3] == PSEL_2112) ? 2048 : 4096;
			seg_w = (cfg[c][1:0] == GRAN_PAGE) ? main_w : (cfg[c][1:0] == GRAN_256) ? 256 : 512;
			if (w16 && cfg[c][1:0] != GRAN_PAGE)
				seg_w = seg_w / 2;
			nseg = (main_w / seg_w > 16) ? 16 : main_w / seg_w;
			// mode layout: length in [1:0], word width in [2], granularity in [5:4]
			wr(OFS_MODE, {26'h0, cfg[c][1:0], 1'b0, cfg[c][2], cfg[c][4:3]});
			for (int k = 0; k < 4160; k++) npe_flash_model_i.mem[k] = 16'($urandom);
			run_flash(CMD_PROG, 13'(main_w));
			check_irq(1'b1);
			rd(OFS_SR1, 32'h8, 32'hf);
			check_irq(1'b0);
			for (int k = 0; k < nseg; k++) rd(pr_ofs(k), calc_code(k * seg_w, seg_w, w16), '1);
			if (nseg < 16) rd(pr_ofs(nseg), 32'h0, '1);
		end
		run_flash(8'h70, 13'd64);
		rd(OFS_PR0, calc_code(0, seg_w, w16), '1);
		wr(OFS_CTRL, 32'h0);
		rd(OFS_PR0, calc_code(0, seg_w, w16), '1);
		wr(OFS_CTRL, 32'h1 << CTRL_PRST);
		rd(OFS_PR0, 32'h0, '1);
		// read-back: clean, one data bit, one code bit, two data bits
		wr(OFS_MODE, 32'h0);
		// recoverable and multiple unmasked, code error masked off
		wr(OFS_MASK, 32'h5);
		for (int c = 0; c < 4; c++) begin
			for (int k = 0; k < 516; k++) npe_flash_model_i.mem[k] = 16'($urandom);
			code = calc_code(0, 512, 1'b0);
			j = $urandom_range(511);
			b = $urandom_range(7);
			if (c == 2)
				code[j % 9] = ~code[j % 9];
			if (c == 1 || c == 3)
				npe_flash_model_i.mem[j][b] = ~npe_flash_model_i.mem[j][b];
			if (c == 3)
				npe_flash_model_i.mem[(j + 1) % 512][b] ^= 1'b1;
			// software stores the code in the spare bytes, low byte first
			for (int k = 0; k < 4; k++) npe_flash_model_i.mem[512 + k] = {8'h00, code[8 * k +: 8]};
			run_flash(CMD_READ, 13'd516);
			check_irq(c == 1 || c == 3);
			rd(OFS_SR1, (c == 0) ? 32'h0 : 32'h1 << (c - 1), 32'h7);
			rd(OFS_SR2, (c == 0) ? 32'h0 : 32'h1, '1);
			if (c == 1)
				rd(OFS_PR0, {16'h0, 12'(j), 4'(b)}, '1);
		end
		run_flash(CMD_READ, 13'd516);
		wr(OFS_CTRL, 32'h1 << CTRL_SRST);
		rd(OFS_SR1, 32'h0, 32'hf);
		finish_test();
	end
endmodule
